// ===== hw/pbm_pin_sync.sv
// three-stage input synchroniser with second/third agreement filter
`timescale 1ns/1ps
`default_nettype none
module pbm_pin_sync (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset_n,
   // raw pad level and filtered result
   input  wire logic pad_in,
   output logic      level
);
   import pbm_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] sh;
      logic              lvl;
   } pbm_sync_s;

   pbm_sync_s st_r;
   pbm_sync_s st_nxt;

   // shift and accept a change only when stages two and three agree
   always_comb begin
      st_nxt     = st_r;
      st_nxt.sh  = {st_r.sh[1:0], pad_in};
      if (st_r.sh[1] == st_r.sh[2]) begin
         st_nxt.lvl = st_r.sh[2];
      end
   end

   // register the state, pulled-up level after reset
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_r.sh  <= RST_SYNC;
         st_r.lvl <= RST_LVL;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level = st_r.lvl;
endmodule : pbm_pin_sync
`default_nettype wire

// ===== hw/pbm_pkg.sv
// constants and types for the port b pin function multiplexer
`default_nettype none
package pbm_pkg;
   localparam int NUM_PINS = 4;
   localparam int SEL_W    = 3;
   localparam int SYNC_W   = 3;
   localparam int CKSEL_W  = 3;
   // function select codes, shared by all pins
   localparam logic [2:0] FN_GPIO = 3'h0;
   localparam logic [2:0] FN_ALT1 = 3'h1;
   localparam logic [2:0] FN_ALT2 = 3'h2;
   localparam logic [2:0] FN_ALT3 = 3'h3;
   localparam logic [2:0] FN_ALT4 = 3'h4;
   localparam logic [2:0] FN_ALT5 = 3'h5;
   // pin indices inside the four-pin group
   localparam int P2 = 0;
   localparam int P3 = 1;
   localparam int P4 = 2;
   localparam int P5 = 3;
   // reset values
   localparam logic [3:0] RST_DIR  = 4'h0;
   localparam logic [3:0] RST_PULL = 4'hF;
   localparam logic [2:0] RST_SYNC = 3'h7;
   localparam logic       RST_LVL  = 1'h1;
   localparam logic       INACTIVE_HI = 1'h1;
   localparam logic       INACTIVE_LO = 1'h0;
endpackage : pbm_pkg
`default_nettype wire

// ===== hw/pbm_port_b_mux.sv
// pin function multiplexer for port b pins 2 to 5
// Behaviour
// - after reset every pin is gpio input with pull-up on
// - each pin has its own gpio direction bit
// - function choice comes from system integration module selects
// - pin2 offers serial0 miso, timer a ch2, pwm source pair45
// - slave not selected: miso driver is released to high impedance
// - slave drives miso half serial clock before master sample edge
// - master drives mosi half serial clock before slave sample edge
// - pin3 offers serial0 mosi, timer a ch3, pwm source pair23
// - pin4 offers serial1 select, timer b0, timer a0, pair01, clock out
// - external master asserts serial1 select to address this port
// - clock out carries the clock chosen by the clock-out select field
// - pin5 offers timer a ch1 and fault input that disables pwm
// - pin5 can be external clock input to clock generation
// - external clock use also needs oscillator clock mode bit
`timescale 1ns/1ps
`default_nettype none
module pbm_port_b_mux (
   // clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      reset_n,
   // pads, output enables active low
   input  wire logic [pbm_pkg::NUM_PINS-1:0] pad_in,
   output logic [pbm_pkg::NUM_PINS-1:0]   pad_out,
   output logic [pbm_pkg::NUM_PINS-1:0]   pad_oe_n,
   output logic [pbm_pkg::NUM_PINS-1:0]   pad_pullup_en,
   // function selects from system integration module
   input  wire logic [pbm_pkg::SEL_W-1:0] pin2_fn_sel,
   input  wire logic [pbm_pkg::SEL_W-1:0] pin3_fn_sel,
   input  wire logic [pbm_pkg::SEL_W-1:0] pin4_fn_sel,
   input  wire logic [pbm_pkg::SEL_W-1:0] pin5_fn_sel,
   input  wire logic                      oscillator_clock_mode_bit,
   // gpio controller
   input  wire logic [pbm_pkg::NUM_PINS-1:0] gpio_dir,
   input  wire logic [pbm_pkg::NUM_PINS-1:0] gpio_out,
   input  wire logic [pbm_pkg::NUM_PINS-1:0] gpio_pull_en,
   output logic [pbm_pkg::NUM_PINS-1:0]   gpio_in,
   // serial port 0 data
   input  wire logic                      serial0_slave_mode,
   input  wire logic                      serial0_selected,
   input  wire logic                      serial0_master_in_data_out,
   input  wire logic                      serial0_master_out_data_out,
   output logic                           serial0_master_in_data,
   output logic                           serial0_master_out_data,
   // serial port 1 select
   output logic                           serial1_slave_select_n,
   // timer channels, output value and drive enable
   input  wire logic [3:0]                timer_a_out,
   input  wire logic [3:0]                timer_a_oe,
   output logic [3:0]                     timer_a_in,
   input  wire logic                      timer_b_channel0_out,
   input  wire logic                      timer_b_channel0_oe,
   output logic                           timer_b_channel0,
   // pwm sources and fault
   output logic                           ext_pwm_source_pair45,
   output logic                           ext_pwm_source_pair23,
   output logic                           ext_pwm_source_pair01,
   output logic                           offchip_fault_input,
   // clocks
   input  wire logic [pbm_pkg::CKSEL_W-1:0] clock_out_source_select,
   input  wire logic [7:0]                clock_sources,
   output logic                           external_clock_input
);
   import pbm_pkg::*;

   typedef struct packed {
      logic [NUM_PINS-1:0] out;
      logic [NUM_PINS-1:0] oe_n;
      logic [NUM_PINS-1:0] pull;
      logic [NUM_PINS-1:0] gin;
      logic                miso;
      logic                mosi;
      logic                ss_n;
      logic [3:0]          ta;
      logic                tb0;
      logic                ps45;
      logic                ps23;
      logic                ps01;
      logic                fault;
      logic                ckin;
   } pbm_state_s;

   pbm_state_s st_r;
   pbm_state_s st_nxt;
   logic [NUM_PINS-1:0] pin_lvl;
   logic                ck_pick;

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers, one per pad
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
         pbm_pin_sync u_sync (
            .clk_sys (clk_sys),
            .reset_n (reset_n),
            .pad_in  (pad_in[gi]),
            .level   (pin_lvl[gi])
         );
      end
   endgenerate

   // clock source picked combinationally, then retimed by the pad output flip-flop
   assign ck_pick = clock_sources[clock_out_source_select];

   ////////////////////////////////////////////////////////////////////////
   // pad and peripheral routing
   always_comb begin
      st_nxt = st_r;
      // gpio default per pin, independent direction
      for (int i = 0; i < NUM_PINS; i++) begin
         st_nxt.out[i]  = gpio_out[i];
         st_nxt.oe_n[i] = ~gpio_dir[i];
         st_nxt.pull[i] = gpio_pull_en[i] & ~gpio_dir[i];
         st_nxt.gin[i]  = pin_lvl[i];
      end
      // inactive levels for inputs not mapped to a pin
      st_nxt.miso  = INACTIVE_LO;
      st_nxt.mosi  = INACTIVE_LO;
      st_nxt.ss_n  = INACTIVE_HI;
      st_nxt.ta    = 4'h0;
      st_nxt.tb0   = INACTIVE_LO;
      st_nxt.ps45  = INACTIVE_LO;
      st_nxt.ps23  = INACTIVE_LO;
      st_nxt.ps01  = INACTIVE_LO;
      st_nxt.fault = INACTIVE_LO;
      st_nxt.ckin  = INACTIVE_LO;
      // pin2: miso, timer a2, pwm source pair45
      unique case (pin2_fn_sel)
         FN_ALT1: begin
            st_nxt.out[P2]  = serial0_master_in_data_out;
            st_nxt.oe_n[P2] = ~(serial0_slave_mode & serial0_selected);
            st_nxt.pull[P2] = 1'h0;
            st_nxt.miso     = pin_lvl[P2];
         end
         FN_ALT2: begin
            st_nxt.out[P2]  = timer_a_out[2];
            st_nxt.oe_n[P2] = ~timer_a_oe[2];
            st_nxt.ta[2]    = pin_lvl[P2];
         end
         FN_ALT3: begin
            st_nxt.oe_n[P2] = 1'h1;
            st_nxt.ps45     = pin_lvl[P2];
         end
         default: begin
         end
      endcase
      // pin3: mosi, timer a3, pwm source pair23
      unique case (pin3_fn_sel)
         FN_ALT1: begin
            st_nxt.out[P3]  = serial0_master_out_data_out;
            st_nxt.oe_n[P3] = serial0_slave_mode;
            st_nxt.mosi     = pin_lvl[P3];
         end
         FN_ALT2: begin
            st_nxt.out[P3]  = timer_a_out[3];
            st_nxt.oe_n[P3] = ~timer_a_oe[3];
            st_nxt.ta[3]    = pin_lvl[P3];
         end
         FN_ALT3: begin
            st_nxt.oe_n[P3] = 1'h1;
            st_nxt.ps23     = pin_lvl[P3];
         end
         default: begin
         end
      endcase
      // pin4: select, timer b0, timer a0, pair01, clock out
      unique case (pin4_fn_sel)
         FN_ALT1: begin
            st_nxt.oe_n[P4] = 1'h1;
            st_nxt.ss_n     = pin_lvl[P4];
         end
         FN_ALT2: begin
            st_nxt.out[P4]  = timer_b_channel0_out;
            st_nxt.oe_n[P4] = ~timer_b_channel0_oe;
            st_nxt.tb0      = pin_lvl[P4];
         end
         FN_ALT3: begin
            st_nxt.out[P4]  = timer_a_out[0];
            st_nxt.oe_n[P4] = ~timer_a_oe[0];
            st_nxt.ta[0]    = pin_lvl[P4];
         end
         FN_ALT4: begin
            st_nxt.oe_n[P4] = 1'h1;
            st_nxt.ps01     = pin_lvl[P4];
         end
         FN_ALT5: begin
            st_nxt.out[P4]  = ck_pick;
            st_nxt.oe_n[P4] = 1'h0;
            st_nxt.pull[P4] = 1'h0;
         end
         default: begin
         end
      endcase
      // pin5: timer a1, fault input, external clock input
      unique case (pin5_fn_sel)
         FN_ALT1: begin
            st_nxt.out[P5]  = timer_a_out[1];
            st_nxt.oe_n[P5] = ~timer_a_oe[1];
            st_nxt.ta[1]    = pin_lvl[P5];
         end
         FN_ALT2: begin
            st_nxt.oe_n[P5] = 1'h1;
            st_nxt.fault    = pin_lvl[P5];
         end
         FN_ALT3: begin
            st_nxt.oe_n[P5] = 1'h1;
            st_nxt.ckin = pin_lvl[P5] & oscillator_clock_mode_bit;
         end
         default: begin
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state register, gpio input with pull-up after reset
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_r       <= '0;
         st_r.oe_n  <= 4'hF;
         st_r.pull  <= RST_PULL;
         st_r.gin   <= 4'hF;
         st_r.ss_n  <= INACTIVE_HI;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flip-flops
   assign pad_out                = st_r.out;
   assign pad_oe_n               = st_r.oe_n;
   assign pad_pullup_en          = st_r.pull;
   assign gpio_in                = st_r.gin;
   assign serial0_master_in_data = st_r.miso;
   assign serial0_master_out_data = st_r.mosi;
   assign serial1_slave_select_n = st_r.ss_n;
   assign timer_a_in             = st_r.ta;
   assign timer_b_channel0       = st_r.tb0;
   assign ext_pwm_source_pair45  = st_r.ps45;
   assign ext_pwm_source_pair23  = st_r.ps23;
   assign ext_pwm_source_pair01  = st_r.ps01;
   assign offchip_fault_input    = st_r.fault;
   assign external_clock_input   = st_r.ckin;
endmodule : pbm_port_b_mux
`default_nettype wire

// ===== testbench/pbm_pad_model.sv
// far-side pad model: external drivers, pull-ups and floating pads
`timescale 1ns/1ps
`default_nettype none
module pbm_pad_model (
   // clock
   input wire logic       clk_sys,
   // pad controls from the multiplexer
   input wire logic [3:0] pad_out, pad_oe_n, pad_pullup_en,
   // external device drive enable and value
   input wire logic [3:0] ext_en, ext_val,
   // resolved pad level
   output logic [3:0]     pad_in
);
   logic [3:0] last_r;
   // last level, so an undriven pad without pull-up keeps changing
   always_ff @(posedge clk_sys) last_r <= pad_in;
   // resolve each wire from every party's drive
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (!pad_oe_n[i])
            pad_in[i] = pad_out[i];
         else if (ext_en[i])
            pad_in[i] = ext_val[i];
         else
            pad_in[i] = pad_pullup_en[i] | !last_r[i];
      end
   end
endmodule : pbm_pad_model
`default_nettype wire

// ===== testbench/pbm_port_b_mux_monitor.sv
// concurrent checks on the port b pin multiplexer ports
`timescale 1ns/1ps
`default_nettype none
module pbm_port_b_mux_monitor (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       reset_n,
   // pads
   input wire logic [3:0] pad_in, pad_out, pad_oe_n, pad_pullup_en,
   // selects and controls
   input wire logic [2:0] pin2_fn_sel, pin3_fn_sel, pin4_fn_sel,
   input wire logic [2:0] pin5_fn_sel, clock_out_source_select,
   input wire logic [3:0] gpio_dir, timer_a_out, timer_a_oe,
   input wire logic [7:0] clock_sources,
   // peripheral side
   input wire logic       oscillator_clock_mode_bit, serial0_slave_mode,
   input wire logic       serial0_selected, serial0_master_in_data_out,
   input wire logic       serial0_master_out_data_out,
   input wire logic       offchip_fault_input, external_clock_input
);
   import pbm_pkg::*;
   logic ck_pick;
   // source that the clock output must copy
   assign ck_pick = clock_sources[clock_out_source_select];
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////
   a_reset_gpio_in: assert property (
      $rose(reset_n) |-> pad_oe_n == 4'hF && pad_pullup_en == 4'hF)
      else $error("pins not gpio inputs after reset");
   a_gpio_dir_own: assert property (
      pin2_fn_sel == FN_GPIO |=> pad_oe_n[0] == !$past(gpio_dir[0]))
      else $error("gpio direction not followed");
   a_miso_release: assert property (
      pin2_fn_sel == FN_ALT1 && !(serial0_slave_mode && serial0_selected)
      |=> pad_oe_n[0]) else $error("miso driven while unselected");
   a_miso_drive: assert property (
      pin2_fn_sel == FN_ALT1 && serial0_slave_mode && serial0_selected
      |=> !pad_oe_n[0] && pad_out[0] == $past(serial0_master_in_data_out))
      else $error("miso data not driven");
   a_mosi_drive: assert property (
      pin3_fn_sel == FN_ALT1 && !serial0_slave_mode |=> !pad_oe_n[1]
      && pad_out[1] == $past(serial0_master_out_data_out))
      else $error("mosi data not driven");
   a_timer_drive: assert property (
      pin2_fn_sel == FN_ALT2 |=> pad_out[0] == $past(timer_a_out[2])
      && pad_oe_n[0] != $past(timer_a_oe[2]))
      else $error("timer a channel 2 not on pad");
   a_clock_out_copy: assert property (
      pin4_fn_sel == FN_ALT5 |=> !pad_oe_n[2] && pad_out[2] == $past(ck_pick))
      else $error("clock output not the selected source");
   a_fault_follows: assert property (
      (pin5_fn_sel == FN_ALT2 && $stable(pad_in[3]))[*6]
      |-> offchip_fault_input == pad_in[3])
      else $error("fault input not the pad level");
   a_extclk_gated: assert property (
      (!oscillator_clock_mode_bit)[*2] |=> !external_clock_input)
      else $error("external clock passed with mode bit off");
   a_fault_unmapped: assert property (
      (pin5_fn_sel != FN_ALT2)[*2] |=> !offchip_fault_input)
      else $error("unmapped fault input not inactive");
endmodule : pbm_port_b_mux_monitor
bind pbm_port_b_mux pbm_port_b_mux_monitor u_mon (.*);
`default_nettype wire

// ===== testbench/pbm_port_b_mux_tb_top.sv
// self-checking testbench for the port b pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module pbm_port_b_mux_tb_top;
   import pbm_pkg::*;
   logic clk_sys, reset_n, oscillator_clock_mode_bit;
   logic [2:0] pin2_fn_sel, pin3_fn_sel, pin4_fn_sel, pin5_fn_sel;
   logic [2:0] clock_out_source_select;
   logic [3:0] pad_in, pad_out, pad_oe_n, pad_pullup_en, ext_en, ext_val;
   logic [3:0] gpio_dir, gpio_out, gpio_pull_en, gpio_in;
   logic [3:0] timer_a_out, timer_a_oe, timer_a_in;
   logic [7:0] clock_sources;
   logic serial0_slave_mode, serial0_selected, serial0_master_in_data_out;
   logic serial0_master_out_data_out, serial0_master_in_data;
   logic serial0_master_out_data, serial1_slave_select_n;
   logic timer_b_channel0_out, timer_b_channel0_oe, timer_b_channel0;
   logic ext_pwm_source_pair45, ext_pwm_source_pair23;
   logic ext_pwm_source_pair01, offchip_fault_input, external_clock_input;
   int n_errors, checks;
   pbm_port_b_mux dut (.*);
   pbm_pad_model u_pads (.*);
   ////////////////////////////////////////////////////////////////////////
   // compare, wait and verdict helpers
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wt(int n);
      repeat (n) @(negedge clk_sys);
   endtask : wt
   task automatic end_of_test();
      if (n_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////
   // reset: pins are pulled-up gpio inputs, pad levels reach gpio_in after
   task automatic t_reset();
      reset_n = 1'b0;
      wt(7);
      chk("rst", 8'hFF, {pad_oe_n, pad_pullup_en});
      chk("rst_in", 8'h0F, gpio_in);
      reset_n = 1'b1;
      wt(6);
      chk("rst_gin", {4'h0, ext_val | ~ext_en}, gpio_in);
   endtask : t_reset
   // mixed gpio directions, two pins driven from outside
   task automatic t_gpio();
      {gpio_dir, gpio_out, ext_en, ext_val} = 16'h51A0;
      wt(6);
      chk("oe_n", 4'hA, pad_oe_n);
      chk("out", 4'h1, pad_out & 4'h5);
      chk("gpio_in", 4'h1, gpio_in);
      chk("pull", 4'hA, pad_pullup_en);
      {gpio_dir, ext_en} = '0;
   endtask : t_gpio
   // pin2: miso in all select states, master input, pwm source, timer
   task automatic t_pin2();
      pin2_fn_sel = FN_ALT1;
      serial0_master_in_data_out = 1'b1;
      for (int k = 0; k < 4; k++) begin
         {serial0_slave_mode, serial0_selected} = k[1:0];
         wt(2);
         chk("miso_oe_n", k != 3, pad_oe_n[0]);
         chk("miso_pad", k == 3, pad_out[0] & !pad_oe_n[0]);
      end
      {serial0_slave_mode, ext_en, ext_val} = 9'h011;
      wt(6);
      chk("miso_in", 8'h1, serial0_master_in_data);
      pin2_fn_sel = FN_ALT3;
      wt(6);
      chk("pair45", 8'h1, ext_pwm_source_pair45);
      {pin2_fn_sel, timer_a_oe, timer_a_out} = {FN_ALT2, 8'h44};
      wt(2);
      chk("ta2_pad", 8'h1, {pad_oe_n[0], pad_out[0]});
      timer_a_oe = 4'h0;
      wt(6);
      chk("ta2_in", 8'h1, timer_a_in[2]);
      {pin2_fn_sel, timer_a_oe, ext_en} = '0;
   endtask : t_pin2
   // pin3: mosi out as master, mosi in as slave, timer input, pwm source
   task automatic t_pin3();
      {pin3_fn_sel, serial0_master_out_data_out} = {FN_ALT1, 1'b1};
      wt(2);
      chk("mosi_pad", 8'h1, {pad_oe_n[1], pad_out[1]});
      {serial0_slave_mode, ext_en, ext_val} = 9'h122;
      wt(6);
      chk("mosi_in", 8'h3, {pad_oe_n[1], serial0_master_out_data});
      pin3_fn_sel = FN_ALT2;
      wt(6);
      chk("ta3_in", 8'h1, timer_a_in[3]);
      pin3_fn_sel = FN_ALT3;
      wt(6);
      chk("pair23", 8'h1, ext_pwm_source_pair23);
      {pin3_fn_sel, serial0_slave_mode, ext_en} = '0;
   endtask : t_pin3
   // pin4: select low and high, inputs, timer b drive, every clock source
   task automatic t_pin4();
      {pin4_fn_sel, ext_en, ext_val} = {FN_ALT1, 8'h40};
      wt(6);
      chk("ss_lo", 8'h0, serial1_slave_select_n);
      ext_val = 4'h4;
      wt(6);
      chk("ss_hi", 8'h1, serial1_slave_select_n);
      pin4_fn_sel = FN_ALT4;
      wt(6);
      chk("pair01", 8'h1, ext_pwm_source_pair01);
      pin4_fn_sel = FN_ALT3;
      wt(6);
      chk("ta0_in", 8'h1, timer_a_in[0]);
      pin4_fn_sel = FN_ALT2;
      wt(6);
      chk("tb0_in", 8'h1, timer_b_channel0);
      timer_b_channel0_oe = 1'b1;
      wt(2);
      chk("tb0_pad", 8'h0, {pad_oe_n[2], pad_out[2]});
      {pin4_fn_sel, clock_sources, ext_en} = {FN_ALT5, 8'h04, 4'h0};
      for (int s = 0; s < 8; s++) begin
         clock_out_source_select = s[2:0];
         wt(2);
         chk("clk_out", s == 2, pad_out[2]);
      end
      {pin4_fn_sel, timer_b_channel0_oe} = '0;
   endtask : t_pin4
   // pin5: fault, timer input, external clock gated by the mode bit
   task automatic t_pin5();
      {pin5_fn_sel, ext_en, ext_val} = {FN_ALT2, 8'h88};
      wt(6);
      chk("fault", 8'h1, offchip_fault_input);
      pin5_fn_sel = FN_ALT1;
      wt(6);
      chk("ta1_fault", 8'h2, {timer_a_in[1], offchip_fault_input});
      pin5_fn_sel = FN_ALT3;
      wt(6);
      chk("clk_off", 8'h0, external_clock_input);
      oscillator_clock_mode_bit = 1'b1;
      wt(6);
      chk("clk_on", 8'h1, external_clock_input);
      ext_val = 4'h0;
      wt(6);
      chk("clk_lo", 8'h0, external_clock_input);
   endtask : t_pin5
   // all pins gpio with pads driven: every peripheral input reads inactive
   task automatic t_unmapped();
      {pin5_fn_sel, ext_en, ext_val} = {FN_GPIO, 8'hFB};
      wt(6);
      chk("unmapped", 8'h20, {serial0_master_in_data, serial0_master_out_data,
          serial1_slave_select_n, timer_b_channel0, ext_pwm_source_pair45,
          ext_pwm_source_pair23, ext_pwm_source_pair01,
          offchip_fault_input});
      chk("unmapped_ta", 8'h0, timer_a_in);
      chk("unmapped_ck", 8'h0, external_clock_input);
   endtask : t_unmapped
   ////////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // hang guard
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_errors++;
      end_of_test();
   end
   // main sequence
   initial begin
      {oscillator_clock_mode_bit, pin2_fn_sel, pin3_fn_sel,
       pin4_fn_sel, pin5_fn_sel, clock_out_source_select, ext_en, ext_val,
       gpio_dir, gpio_out, timer_a_out, timer_a_oe,
       clock_sources, serial0_slave_mode, serial0_selected,
       serial0_master_in_data_out, serial0_master_out_data_out,
       timer_b_channel0_out, timer_b_channel0_oe} = '0;
      gpio_pull_en = 4'hF;
      t_reset();
      t_gpio();
      t_pin2();
      t_pin3();
      t_pin4();
      t_pin5();
      t_unmapped();
      t_reset();
      end_of_test();
   end
endmodule : pbm_port_b_mux_tb_top
`default_nettype wire
